// >>> status_pkg.sv
/*
 holds constants for the alu and reset status register
 assumes a single instruction-cycle clock domain
*/
package status_pkg;
	localparam logic [7:0] STATUS_ADDR     = 8'h03;
	localparam int         BIT_CARRY       = 0;
	localparam int         BIT_HALF_CARRY  = 1;
	localparam int         BIT_ZERO        = 2;
	localparam int         BIT_POWERDOWN   = 3;
	localparam int         BIT_WDT_EXPIRED = 4;
	localparam int         BIT_BANK_LO     = 5;
	localparam int         BIT_BANK_HI     = 6;
	localparam int         BIT_SPARE       = 7;
	localparam logic [2:0] UPPER_RESET     = 3'h0;
	localparam logic [1:0] RESETFLAG_POR   = 2'h3;
	localparam logic [2:0] ARITH_RESET     = 3'h0;
	localparam logic [7:0] FLAG_WRITE_MASK = 8'h07;
	localparam logic [7:0] RO_MASK         = 8'h18;
endpackage

// >>> status_flag_unit.sv
/*
 computes zero, half-carry and carry flags for an instruction result
 assumes operands and opcode class arrive on the same clock
*/
`timescale 1ns/100ps
`default_nettype none
module status_flag_unit
	import status_pkg::*;
(
	// operands
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       carry_in,
	// operation class
	input  wire logic       is_add,
	input  wire logic       is_sub,
	input  wire logic       is_rotate_right,
	input  wire logic       is_rotate_left,
	input  wire logic [7:0] logic_result,
	// flags
	output logic            zero,
	output logic            half_carry,
	output logic            carry
);
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic [7:0] result;

	always_comb begin
		sum        = 9'h000;
		low_sum    = 5'h00;
		result     = logic_result;
		half_carry = 1'b0;
		carry      = carry_in;
		if (is_add) begin
			sum        = {1'b0, a} + {1'b0, b};
			low_sum    = {1'b0, a[3:0]} + {1'b0, b[3:0]};
			result     = sum[7:0];
			half_carry = low_sum[4];
			carry      = sum[8];
		end else if (is_sub) begin
			sum        = {1'b0, a} + {1'b0, ~b} + 9'h001;
			low_sum    = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
			result     = sum[7:0];
			half_carry = low_sum[4];
			carry      = sum[8];
		end else if (is_rotate_right) begin
			carry = a[0];
		end else if (is_rotate_left) begin
			carry = a[7];
		end
		zero = (result == 8'h00);
	end
endmodule
`default_nettype wire

// >>> alu_reset_status_register.sv
/*
 holds the alu and reset status register with write masking
 assumes datapath drives write strobes and flag updates on CLOCK
*/
`timescale 1ns/100ps
`default_nettype none
// Function
// - one byte holds alu flags, reset-cause flags and page preselect bits
// - register is writable as destination of any instruction
// - flag-updating instruction to this register masks data writes to zero, half carry and carry flags
// - data writes never change time-out or power-down flags
// - register-clear zeroes upper three bits, sets zero, keeps other bits
// - page preselect bits choose program memory page above 512 words
// - add sets half carry on carry out of low nibble
// - subtract sets half carry when no borrow from low nibble
// - ARST_N clears the page preselect bits; power-up, kick, sleep and time-out events keep them
// - bits 5 and 6 feed program counter bits 9 and 10 on branch
module alu_reset_status_register
	import status_pkg::*;
(
	// clock and reset
	input  wire logic       CLOCK,
	input  wire logic       ARST_N,
	input  wire logic       CE,
	// data write from datapath
	input  wire logic [7:0] WR_ADDR,
	input  wire logic [7:0] WR_DATA,
	input  wire logic       WR_EN,
	input  wire logic       CLEAR_OP,
	// flag update from instruction
	input  wire logic       FLAG_UPDATE,
	input  wire logic       UPD_ZERO,
	input  wire logic       UPD_HALF,
	input  wire logic       UPD_CARRY,
	input  wire logic [7:0] ALU_A,
	input  wire logic [7:0] ALU_B,
	input  wire logic [7:0] LOGIC_RESULT,
	input  wire logic       OP_ADD,
	input  wire logic       OP_SUB,
	input  wire logic       OP_ROTATE_RIGHT,
	input  wire logic       OP_ROTATE_LEFT,
	// reset cause events
	input  wire logic       POWER_UP,
	input  wire logic       WATCHDOG_KICK,
	input  wire logic       SLEEP_OP,
	input  wire logic       WDT_TIMEOUT,
	// program counter load
	input  wire logic       PC_LOAD,
	// outputs
	output logic [7:0]      STATUS_OUT,
	output logic [1:0]      PC_PAGE_BITS
);
	typedef struct packed {
		logic [7:0] status;
		logic [1:0] page_latch;
	} state_t;

	state_t state_reg;
	state_t state_next;
	logic   f_zero;
	logic   f_half;
	logic   f_carry;
	logic   hit;

	status_flag_unit status_flag_unit_inst (
		.a               (ALU_A),
		.b               (ALU_B),
		.carry_in        (state_reg.status[BIT_CARRY]),
		.is_add          (OP_ADD),
		.is_sub          (OP_SUB),
		.is_rotate_right (OP_ROTATE_RIGHT),
		.is_rotate_left  (OP_ROTATE_LEFT),
		.logic_result    (LOGIC_RESULT),
		.zero            (f_zero),
		.half_carry      (f_half),
		.carry           (f_carry)
	);

	assign hit = WR_EN && (WR_ADDR == STATUS_ADDR);

	always_comb begin
		state_next = state_reg;
		// instruction data write
		if (hit) begin
			if (CLEAR_OP) begin
				state_next.status[7:5]      = UPPER_RESET;
				state_next.status[BIT_ZERO] = 1'b1;
			end else begin
				for (int i = 0; i < 8; i++) begin
					if (!RO_MASK[i] && !(FLAG_UPDATE && FLAG_WRITE_MASK[i])) begin
						state_next.status[i] = WR_DATA[i];
					end
				end
			end
		end
		// flags from instruction logic, clear of this register wins
		if (FLAG_UPDATE && !(hit && CLEAR_OP)) begin
			if (UPD_ZERO) begin
				state_next.status[BIT_ZERO] = f_zero;
			end
			if (UPD_HALF) begin
				state_next.status[BIT_HALF_CARRY] = f_half;
			end
			if (UPD_CARRY) begin
				state_next.status[BIT_CARRY] = f_carry;
			end
		end
		// reset-cause events
		if (POWER_UP || WATCHDOG_KICK) begin
			state_next.status[BIT_WDT_EXPIRED] = 1'b1;
			state_next.status[BIT_POWERDOWN]   = 1'b1;
		end else if (SLEEP_OP) begin
			state_next.status[BIT_WDT_EXPIRED] = 1'b1;
			state_next.status[BIT_POWERDOWN]   = 1'b0;
		end else if (WDT_TIMEOUT) begin
			state_next.status[BIT_WDT_EXPIRED] = 1'b0;
		end
		// page latch for program counter load
		if (PC_LOAD) begin
			state_next.page_latch = state_reg.status[BIT_BANK_HI:BIT_BANK_LO];
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_reg.status     <= {UPPER_RESET, RESETFLAG_POR, ARITH_RESET};
			state_reg.page_latch <= 2'h0;
		end else if (CE) begin
			state_reg <= state_next;
		end
	end

	assign STATUS_OUT   = state_reg.status;
	assign PC_PAGE_BITS = state_reg.page_latch;

	// write path, event, page, half-carry and enable checks
	ro_flags_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && hit && !POWER_UP && !WATCHDOG_KICK && !SLEEP_OP && !WDT_TIMEOUT
		|=> $stable(STATUS_OUT[4:3]))
		else $error("reset flags changed by write");
	clear_op_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && hit && CLEAR_OP |=> STATUS_OUT[7:5] == 3'h0 && STATUS_OUT[BIT_ZERO]
		&& STATUS_OUT[1:0] == $past(STATUS_OUT[1:0]))
		else $error("register clear wrong");
	mask_flags_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && hit && FLAG_UPDATE && !CLEAR_OP && !UPD_ZERO && !UPD_HALF
		|=> STATUS_OUT[2:1] == $past(STATUS_OUT[2:1]))
		else $error("masked flags taken from write data");
	plain_write_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && hit && !FLAG_UPDATE && !CLEAR_OP |=> STATUS_OUT[7:5] == $past(WR_DATA[7:5])
		&& STATUS_OUT[2:0] == $past(WR_DATA[2:0]))
		else $error("data write lost");
	sleep_flags_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && SLEEP_OP && !POWER_UP && !WATCHDOG_KICK |=> STATUS_OUT[4:3] == 2'b10)
		else $error("sleep flags wrong");
	timeout_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && WDT_TIMEOUT && !POWER_UP && !WATCHDOG_KICK && !SLEEP_OP
		|=> !STATUS_OUT[BIT_WDT_EXPIRED])
		else $error("time-out flag not cleared");
	page_load_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && PC_LOAD |=> PC_PAGE_BITS == $past(STATUS_OUT[6:5]))
		else $error("page bits not loaded");
	half_add_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && FLAG_UPDATE && UPD_HALF && OP_ADD && !CLEAR_OP
		|=> STATUS_OUT[BIT_HALF_CARRY]
		== ({1'b0, $past(ALU_A[3:0])} + {1'b0, $past(ALU_B[3:0])} > 5'h0F))
		else $error("half carry on add wrong");
	half_sub_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && FLAG_UPDATE && UPD_HALF && OP_SUB && !CLEAR_OP
		|=> STATUS_OUT[BIT_HALF_CARRY] == ($past(ALU_A[3:0]) >= $past(ALU_B[3:0])))
		else $error("half carry on sub wrong");
	freeze_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		!CE |=> $stable(STATUS_OUT) && $stable(PC_PAGE_BITS))
		else $error("state moved without enable");

	// carry and zero from flag logic
	add_carry_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && FLAG_UPDATE && UPD_CARRY && OP_ADD && !(hit && CLEAR_OP)
		|=> STATUS_OUT[BIT_CARRY] == ({1'b0, $past(ALU_A)} + {1'b0, $past(ALU_B)} > 9'h0FF))
		else $error("carry on add wrong");
	add_zero_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && FLAG_UPDATE && UPD_ZERO && OP_ADD && !(hit && CLEAR_OP)
		|=> STATUS_OUT[BIT_ZERO] == ($past(ALU_A) + $past(ALU_B) == 8'h00))
		else $error("zero on add wrong");
	sub_carry_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && FLAG_UPDATE && UPD_CARRY && OP_SUB && !OP_ADD && !(hit && CLEAR_OP)
		|=> STATUS_OUT[BIT_CARRY] == ($past(ALU_A) >= $past(ALU_B)))
		else $error("no-borrow on subtract wrong");
	right_carry_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && FLAG_UPDATE && UPD_CARRY && OP_ROTATE_RIGHT && !OP_ADD && !OP_SUB
		&& !(hit && CLEAR_OP) |=> STATUS_OUT[BIT_CARRY] == $past(ALU_A[0]))
		else $error("carry on rotate right wrong");
	left_carry_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && FLAG_UPDATE && UPD_CARRY && OP_ROTATE_LEFT && !OP_ROTATE_RIGHT && !OP_ADD
		&& !OP_SUB && !(hit && CLEAR_OP) |=> STATUS_OUT[BIT_CARRY] == $past(ALU_A[7]))
		else $error("carry on rotate left wrong");
	logic_zero_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && FLAG_UPDATE && UPD_ZERO && !OP_ADD && !OP_SUB && !(hit && CLEAR_OP)
		|=> STATUS_OUT[BIT_ZERO] == ($past(LOGIC_RESULT) == 8'h00))
		else $error("zero on logic result wrong");

	// reset-cause and page checks
	kick_flags_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && (POWER_UP || WATCHDOG_KICK) |=> STATUS_OUT[4:3] == 2'b11)
		else $error("power-up or kick flags wrong");
	clear_keep_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && hit && CLEAR_OP && !POWER_UP && !WATCHDOG_KICK && !SLEEP_OP && !WDT_TIMEOUT
		|=> $stable(STATUS_OUT[4:3]))
		else $error("register clear moved reset flags");
	page_hold_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		CE && !PC_LOAD |=> $stable(PC_PAGE_BITS))
		else $error("page bits moved without load");
	page_reset_a: assert property (@(posedge CLOCK)
		!ARST_N && !$past(ARST_N) |-> PC_PAGE_BITS == 2'h0 && STATUS_OUT[6:5] == 2'h0)
		else $error("page bits not cleared by reset");

	write_cov: cover property (@(posedge CLOCK) CE && hit && !CLEAR_OP);
	clear_cov: cover property (@(posedge CLOCK) CE && hit && CLEAR_OP);
	sleep_cov: cover property (@(posedge CLOCK) CE && SLEEP_OP);
	add_cov:   cover property (@(posedge CLOCK) CE && FLAG_UPDATE && OP_ADD && f_half);
	rotate_cov: cover property (@(posedge CLOCK) CE && FLAG_UPDATE && (OP_ROTATE_RIGHT || OP_ROTATE_LEFT));
endmodule
`default_nettype wire

// >>> datapath_model.sv
/*
 instruction datapath model driving one instruction per call
 assumes go is called right after a rising CLOCK
*/
`timescale 1ns/100ps
`default_nettype none
module datapath_model (
	// clock
	input  wire logic       CLOCK,
	// instruction strobes
	output logic            CE,
	output logic            WR_EN,
	output logic            CLEAR_OP,
	output logic            FLAG_UPDATE,
	output logic            UPD_ZERO,
	output logic            UPD_HALF,
	output logic            UPD_CARRY,
	output logic            OP_ADD,
	output logic            OP_SUB,
	output logic            OP_ROTATE_RIGHT,
	output logic            OP_ROTATE_LEFT,
	// events
	output logic            POWER_UP,
	output logic            WATCHDOG_KICK,
	output logic            SLEEP_OP,
	output logic            WDT_TIMEOUT,
	output logic            PC_LOAD,
	// operands
	output logic [7:0]      WR_ADDR,
	output logic [7:0]      WR_DATA,
	output logic [7:0]      ALU_A,
	output logic [7:0]      ALU_B,
	output logic [7:0]      LOGIC_RESULT
);
	logic [15:0] ctl = 16'h8000;
	logic [39:0] dat = 40'h0;
	assign {CE, WR_EN, CLEAR_OP, FLAG_UPDATE, UPD_ZERO, UPD_HALF, UPD_CARRY, OP_ADD, OP_SUB,
		OP_ROTATE_RIGHT, OP_ROTATE_LEFT, POWER_UP, WATCHDOG_KICK, SLEEP_OP, WDT_TIMEOUT,
		PC_LOAD} = ctl;
	assign {WR_ADDR, WR_DATA, ALU_A, ALU_B, LOGIC_RESULT} = dat;
	// one instruction cycle, then operands released to inverted values
	task automatic go(input logic [15:0] c, input logic [39:0] d);
		ctl <= c;
		dat <= d;
		@(posedge CLOCK);
		ctl <= 16'h8000;
		dat <= ~d;
	endtask
endmodule
`default_nettype wire

// >>> tb_alu_reset_status_register.sv
/*
 bench for the alu and reset status register
 assumes datapath_model drives every instruction input
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module tb_alu_reset_status_register;
	import status_pkg::*;
	localparam logic [15:0] en = 16'h8000, wrt = 16'h4000, clr = 16'h2000, pcl = 16'h0001;
	localparam logic [15:0] adf = 16'h1F00, sbf = 16'h1E80, rrc = 16'h1240, rlc = 16'h1220;
	logic            CLOCK, ARST_N;
	wire logic       CE, WR_EN, CLEAR_OP, FLAG_UPDATE, UPD_ZERO, UPD_HALF, UPD_CARRY;
	wire logic       OP_ADD, OP_SUB, OP_ROTATE_RIGHT, OP_ROTATE_LEFT, POWER_UP, WATCHDOG_KICK;
	wire logic       SLEEP_OP, WDT_TIMEOUT, PC_LOAD;
	wire logic [7:0] WR_ADDR, WR_DATA, ALU_A, ALU_B, LOGIC_RESULT, STATUS_OUT;
	wire logic [1:0] PC_PAGE_BITS;
	int              num_errors = 0;
	int              num_checks = 0;
	logic [15:0]     ev [7] = '{16'h0004, 16'h0002, 16'h0008, 16'h0006, 16'h000C, 16'h0002, 16'h0010};
	logic [7:0]      ex [7] = '{8'h30, 8'h20, 8'h38, 8'h30, 8'h38, 8'h28, 8'h38};
	datapath_model datapath_model_inst (.*);
	alu_reset_status_register alu_reset_status_register_inst (.*);
	initial begin
		CLOCK = 1'b0;
		forever #2 CLOCK = ~CLOCK;
	end
	// one instruction, then compare the register one cycle later
	task automatic op(input logic [15:0] c, input logic [39:0] d, input logic [7:0] e);
		@(posedge CLOCK);
		datapath_model_inst.go(c ^ en, d);
		#1;
		`CHK(STATUS_OUT, e)
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		ARST_N = 1'b0;
		repeat (3) @(posedge CLOCK);
		`CHK(STATUS_OUT, 8'h18)
		`CHK(PC_PAGE_BITS, 2'h0)
		ARST_N <= 1'b1;
		$display("test reset done");
		op(wrt, 40'h03E7000000, 8'hFF);
		op(wrt, 40'h0400000000, 8'hFF);
		op(wrt | clr, 40'h0300000000, 8'h1F);
		$display("test writes done");
		op(wrt | adf, 40'h03100F0100, 8'h1A);
		op(wrt | adf, 40'h0400F02000, 8'h19);
		op(wrt | adf, 40'h0400FF0100, 8'h1F);
		op(wrt | sbf, 40'h0400100100, 8'h19);
		op(wrt | sbf, 40'h0400010200, 8'h18);
		op(wrt | sbf, 40'h0400050500, 8'h1F);
		op(rrc, 40'h0000020000, 8'h1E);
		op(rlc, 40'h0000800000, 8'h1F);
		op(16'h1800, 40'h000000005A, 8'h1B);
		op(wrt | 16'h1300, 40'h03FF010100, 8'hFA);
		$display("test flags done");
		op(wrt, 40'h0360000000, 8'h78);
		op(pcl, 40'h0, 8'h78);
		`CHK(PC_PAGE_BITS, 2'h3)
		op(wrt, 40'h0320000000, 8'h38);
		`CHK(PC_PAGE_BITS, 2'h3)
		op(pcl, 40'h0, 8'h38);
		`CHK(PC_PAGE_BITS, 2'h1)
		$display("test page done");
		for (int i = 0; i < 7; i++) begin
			op(ev[i], 40'h0, ex[i]);
		end
		op(16'h0002, 40'h0, 8'h28);
		op(wrt, 40'h0330000000, 8'h28);
		$display("test events done");
		op(en | wrt | adf | 16'h0005, 40'h03E0FF0100, 8'h28);
		op(wrt | pcl, 40'h03E0000000, 8'hE8);
		@(posedge CLOCK);
		ARST_N <= 1'b0;
		#1;
		`CHK(STATUS_OUT, 8'h18)
		`CHK(PC_PAGE_BITS, 2'h0)
		@(posedge CLOCK);
		ARST_N <= 1'b1;
		op(wrt, 40'h0340000000, 8'h58);
		op(wrt | clr | 16'h1800, 40'h0400000000, 8'h5C);
		op(wrt | clr | adf, 40'h0300FF0100, 8'h1C);
		$display("test hold and reset done");
		summarize();
	end
endmodule
`default_nettype wire
